// File: logic/pattern_pkg.sv
// Constants for the output test pattern generator
package pattern_pkg;
	localparam int          WORD_W        = 12;
	localparam int          SYNC_STAGES   = 2;
	localparam logic [7:0]  TEST_CTRL_ADDR = 8'h0d;
	localparam logic [7:0]  USER1_ADDR    = 8'h19;
	localparam logic [7:0]  USER2_ADDR    = 8'h1b;
	localparam int          PN_RST_A_BIT  = 4;
	localparam int          PN_RST_B_BIT  = 5;
	localparam int          MSB12         = 11;
	localparam int          MSB10         = 9;
	// Mode codes
	localparam logic [3:0]  MODE_OFF      = 4'h0;
	localparam logic [3:0]  MODE_MID      = 4'h1;
	localparam logic [3:0]  MODE_POS_FS   = 4'h2;
	localparam logic [3:0]  MODE_NEG_FS   = 4'h3;
	localparam logic [3:0]  MODE_CHECKER  = 4'h4;
	localparam logic [3:0]  MODE_PN_LONG  = 4'h5;
	localparam logic [3:0]  MODE_PN_SHORT = 4'h6;
	localparam logic [3:0]  MODE_WORD_TGL = 4'h7;
	localparam logic [3:0]  MODE_USER     = 4'h8;
	localparam logic [3:0]  MODE_BIT_TGL  = 4'h9;
	localparam logic [3:0]  MODE_SYNC     = 4'ha;
	localparam logic [3:0]  MODE_ONE_HIGH = 4'hb;
	localparam logic [3:0]  MODE_MIXED    = 4'hc;
	// Pattern words, offset binary reference
	localparam logic [11:0] MID12         = 12'h800;
	localparam logic [11:0] MID10         = 12'h200;
	localparam logic [11:0] ONES12        = 12'hfff;
	localparam logic [11:0] ONES10        = 12'h3ff;
	localparam logic [11:0] ZEROS         = 12'h000;
	localparam logic [11:0] CHK_A12       = 12'haaa;
	localparam logic [11:0] CHK_B12       = 12'h555;
	localparam logic [11:0] CHK_A10       = 12'h2aa;
	localparam logic [11:0] CHK_B10       = 12'h155;
	localparam logic [11:0] SYNC12        = 12'h03f;
	localparam logic [11:0] SYNC10        = 12'h01f;
	localparam logic [11:0] MIX12         = 12'ha33;
	localparam logic [11:0] MIX10         = 12'h263;
	localparam logic [11:0] MASK10        = 12'h3ff;
	// Pseudorandom generators
	localparam int          PN9_W         = 9;
	localparam int          PN9_TAP       = 5;
	localparam int          PN23_W        = 23;
	localparam int          PN23_TAP      = 18;
	localparam logic [8:0]  PN9_SEED      = 9'h1ff;
	localparam logic [22:0] PN23_SEED     = 23'h7fffff;
	localparam int          FIFO_DEPTH    = 16;
endpackage

// File: logic/test_pattern_gen.sv
// Output test pattern generator with sample FIFO
//
// Behaviour
// - Four-bit mode code of control word selects pattern; zero means normal data.
// - Any active test mode replaces analog samples with test words.
// - Bit 4 or bit 5 of the control word reseeds both generators.
// - Code 0001 gives midscale word, converted by data format.
// - Code 0010 gives positive full scale, converted by data format.
// - Code 0011 gives negative full scale, converted by data format.
// - Code 0100 alternates 1010 and 0101 words, no format conversion.
// - Code 0111 alternates all ones and all zeros, no conversion.
// - Code 1000 alternates two user words, no conversion.
// - Code 1001 repeats 1010 word every sample, no conversion.
// - Code 1010 repeats sync word for 12 or 10 bits.
// - Code 1011 repeats word with only MSB set.
// - Code 1100 repeats mixed frequency word, no conversion.
// - All fixed patterns serve 10-bit and 12-bit word lengths.
// - Code 0110 gives 511-bit sequence x^9+x^5+1, format converted.
// - Short sequence seeded all ones, 12 bits per word MSB first.
// - Code 0101 gives 8388607-bit sequence x^23+x^18+1, converted.
// - Long sequence seeded all ones, bit stream inverted.
// - Long sequence words are 12 consecutive bits MSB first.
// - Port disabled: format strap high twos complement, low offset binary.
// - Test strap and port select high at power up force MSB-only word.
// - Frame and bit clocks keep running during strap pattern.
// - Port select high makes serial clock and data ignored.
`timescale 1ns/1ps

// ****************************************
// Sample FIFO
// ****************************************
module sample_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,      // Core clock
	input  wire logic             rst_b_i,    // Synchronised reset, active low
	input  wire logic             in_valid_i, // Write request
	output logic                  in_ready_o, // Not full
	input  wire logic [WIDTH-1:0] in_data_i,  // Write word
	output logic                  out_valid_o,// Not empty
	input  wire logic             out_ready_i,// Read accept
	output logic      [WIDTH-1:0] out_data_o  // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
		$error("sample_fifo: depth must be a power of two of at least 2");
	end

	assign in_ready_o  = (count_r != DEPTH[AW:0]);
	assign out_valid_o = (count_r != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_r[rd_ptr_r];

	always_ff @(posedge clk_i) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_i;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule

// ****************************************
// Pattern generator top
// ****************************************
module test_pattern_gen
	import pattern_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic        core_clk_i,           // Core clock, 25 MHz
	input  wire logic        rst_b_i,              // Reset, active low, async
	input  wire logic        sample_clk_i,         // Sample clock pin
	input  wire logic [11:0] adc_sample_i,         // Converted sample pins
	input  wire logic [5:0]  test_ctrl_i,          // Test control word
	input  wire logic        word_len10_i,         // 10-bit word length
	input  wire logic        twos_comp_i,          // Port-selected format
	input  wire logic [15:0] user_word1_i,         // First user word
	input  wire logic [15:0] user_word2_i,         // Second user word
	input  wire logic        port_select_n_i,      // Serial port select pin
	input  wire logic        format_select_strap_i,// Format strap pin
	input  wire logic        test_pattern_strap_i, // Test strap pin
	input  wire logic        spi_sclk_i,           // Serial clock pin
	input  wire logic        spi_sdio_i,           // Serial data pin
	output logic             spi_sclk_o,           // Gated serial clock
	output logic             spi_sdio_o,           // Gated serial data
	output logic             frame_clock_out_o,    // Frame clock
	output logic             bit_clock_out_o,      // Bit clock
	output logic             strap_mode_o,         // Strap pattern active
	output logic             overflow_o,           // Sample dropped, one cycle
	output logic             out_valid_o,          // Word available
	input  wire logic        out_ready_i,          // Word taken
	output logic [11:0]      out_data_o            // Word to formatter
);
	logic        rst_ff1_r, rst_n;
	logic [2:0]  sclk_sync_r;
	logic [11:0] adc_s1_r, adc_s2_r;
	logic [1:0]  psn_sync_r, fmt_sync_r, tps_sync_r, spc_sync_r, spd_sync_r;
	logic [1:0]  cap_cnt_r;
	logic        strap_mode_r, cap_done_r;
	logic [3:0]  prev_eff_r;
	logic        alt_r;
	logic [8:0]  pn9_r, pn9_nxt;
	logic [22:0] pn23_r, pn23_nxt;
	logic [11:0] pn9_word, pn23_word;
	logic [3:0]  eff_mode;
	logic        len10, twos, port_off, sample_stb, push, fifo_ready, pn_reseed;
	logic        mode_change;
	logic [11:0] gen_word;
	logic [11:0] prev_word_r;
	logic [3:0]  prev_push_mode_r;
	if (DEPTH < 2) begin : g_bad_depth
		$error("test_pattern_gen: FIFO depth too small");
	end

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [11:0] fmt(input logic [11:0] w, input logic l10, input logic tc);
		logic [11:0] r;
		r = w;
		if (tc) begin
			if (l10)
				r[MSB10] = ~w[MSB10];
			else
				r[MSB12] = ~w[MSB12];
		end
		return r;
	endfunction

	function automatic logic [11:0] pick(input logic l10, input logic [11:0] w12,
	                                     input logic [11:0] w10);
		return l10 ? w10 : w12;
	endfunction

	// ****************************************
	// Reset and input synchronisers
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_ff1_r <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			rst_ff1_r <= 1'b1;
			rst_n     <= rst_ff1_r;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sclk_sync_r <= '0;
			adc_s1_r    <= '0;
			adc_s2_r    <= '0;
			psn_sync_r  <= '0;
			fmt_sync_r  <= '0;
			tps_sync_r  <= '0;
			spc_sync_r  <= '0;
			spd_sync_r  <= '0;
		end else begin
			sclk_sync_r <= {sclk_sync_r[1:0], sample_clk_i};
			adc_s1_r    <= adc_sample_i;
			adc_s2_r    <= adc_s1_r;
			psn_sync_r  <= {psn_sync_r[0], port_select_n_i};
			fmt_sync_r  <= {fmt_sync_r[0], format_select_strap_i};
			tps_sync_r  <= {tps_sync_r[0], test_pattern_strap_i};
			spc_sync_r  <= {spc_sync_r[0], spi_sclk_i};
			spd_sync_r  <= {spd_sync_r[0], spi_sdio_i};
		end
	end
	assign sample_stb = sclk_sync_r[1] && !sclk_sync_r[2];
	assign port_off   = psn_sync_r[1];
	// ****************************************
	// Serial pin gating
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			spi_sclk_o <= 1'b0;
			spi_sdio_o <= 1'b0;
		end else begin
			spi_sclk_o <= spc_sync_r[1] && !port_off;
			spi_sdio_o <= spd_sync_r[1] && !port_off;
		end
	end

	// ****************************************
	// Strap capture after reset release
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cap_cnt_r    <= '0;
			cap_done_r   <= 1'b0;
			strap_mode_r <= 1'b0;
		end else if (!cap_done_r) begin
			cap_cnt_r <= cap_cnt_r + 1'b1;
			if (cap_cnt_r == SYNC_STAGES[1:0]) begin
				cap_done_r   <= 1'b1;
				strap_mode_r <= port_off && tps_sync_r[1];
			end
		end
	end
	assign strap_mode_o = strap_mode_r;
	// ****************************************
	// Mode and format resolution
	// ****************************************
	always_comb begin
		if (strap_mode_r)
			eff_mode = MODE_ONE_HIGH;
		else if (port_off)
			eff_mode = MODE_OFF;
		else
			eff_mode = test_ctrl_i[3:0];
	end

	assign twos      = port_off ? fmt_sync_r[1] : twos_comp_i;
	assign len10     = !port_off && word_len10_i;
	assign pn_reseed = !port_off && (test_ctrl_i[PN_RST_A_BIT] || test_ctrl_i[PN_RST_B_BIT]);
	assign mode_change = (eff_mode != prev_eff_r);

	// ****************************************
	// Pseudorandom generators
	// ****************************************
	always_comb begin
		pn9_nxt   = pn9_r;
		pn23_nxt  = pn23_r;
		pn9_word  = '0;
		pn23_word = '0;
		for (int i = 0; i < WORD_W; i++) begin
			pn9_word  = {pn9_word[10:0], pn9_nxt[PN9_W-1]};
			pn9_nxt   = {pn9_nxt[PN9_W-2:0],
			             pn9_nxt[PN9_W-1] ^ pn9_nxt[PN9_TAP-1]};
			pn23_word = {pn23_word[10:0], ~pn23_nxt[PN23_W-1]};
			pn23_nxt  = {pn23_nxt[PN23_W-2:0],
			             pn23_nxt[PN23_W-1] ^ pn23_nxt[PN23_TAP-1]};
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pn9_r  <= PN9_SEED;
			pn23_r <= PN23_SEED;
		end else if (pn_reseed || mode_change) begin
			pn9_r  <= PN9_SEED;
			pn23_r <= PN23_SEED;
		end else if (push) begin
			if (eff_mode == MODE_PN_SHORT)
				pn9_r <= pn9_nxt;
			if (eff_mode == MODE_PN_LONG)
				pn23_r <= pn23_nxt;
		end
	end

	// ****************************************
	// Word selection
	// ****************************************
	always_comb begin
		unique case (eff_mode)
			MODE_OFF:      gen_word = fmt(adc_s2_r, 1'b0, twos);
			MODE_MID:      gen_word = fmt(pick(len10, MID12, MID10), len10, twos);
			MODE_POS_FS:   gen_word = fmt(pick(len10, ONES12, ONES10), len10, twos);
			MODE_NEG_FS:   gen_word = fmt(ZEROS, len10, twos);
			MODE_CHECKER:  gen_word = alt_r ? pick(len10, CHK_B12, CHK_B10)
			                                : pick(len10, CHK_A12, CHK_A10);
			MODE_PN_LONG:  gen_word = fmt(pn23_word, 1'b0, twos);
			MODE_PN_SHORT: gen_word = fmt(pn9_word, 1'b0, twos);
			MODE_WORD_TGL: gen_word = alt_r ? ZEROS : pick(len10, ONES12, ONES10);
			MODE_USER:     gen_word = (alt_r ? user_word2_i[11:0] : user_word1_i[11:0])
			                          & (len10 ? MASK10 : ONES12);
			MODE_BIT_TGL:  gen_word = pick(len10, CHK_A12, CHK_A10);
			MODE_SYNC:     gen_word = pick(len10, SYNC12, SYNC10);
			MODE_ONE_HIGH: gen_word = pick(len10, MID12, MID10);
			MODE_MIXED:    gen_word = pick(len10, MIX12, MIX10);
			default:       gen_word = fmt(adc_s2_r, 1'b0, twos);
		endcase
	end
	// Sample and test words share one path; analog ignored in test
	assign push = sample_stb && fifo_ready;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prev_eff_r <= MODE_OFF;
			alt_r      <= 1'b0;
		end else begin
			prev_eff_r <= eff_mode;
			if (mode_change)
				alt_r <= 1'b0;
			else if (push)
				alt_r <= ~alt_r;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			overflow_o <= 1'b0;
		else
			overflow_o <= sample_stb && !fifo_ready;
	end

	// ****************************************
	// Output clocks, free running
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			frame_clock_out_o <= 1'b0;
			bit_clock_out_o   <= 1'b0;
		end else begin
			frame_clock_out_o <= sclk_sync_r[2];
			bit_clock_out_o   <= ~bit_clock_out_o;
		end
	end

	sample_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i       (core_clk_i),
		.rst_b_i     (rst_n),
		.in_valid_i  (sample_stb),
		.in_ready_o  (fifo_ready),
		.in_data_i   (gen_word),
		.out_valid_o (out_valid_o),
		.out_ready_i (out_ready_i),
		.out_data_o  (out_data_o)
	);

	// ****************************************
	// Checks
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prev_word_r      <= '0;
			prev_push_mode_r <= MODE_OFF;
		end else if (push) begin
			prev_word_r      <= gen_word;
			prev_push_mode_r <= eff_mode;
		end else if (mode_change)
			prev_push_mode_r <= MODE_OFF;
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);
	a_off_passes: assert property (push && eff_mode == MODE_OFF
	                               |-> gen_word == (twos ? adc_s2_r ^ MID12 : adc_s2_r))
		else $error("normal mode did not pass sample");
	a_reseed_gens: assert property (pn_reseed |=> pn9_r == PN9_SEED && pn23_r == PN23_SEED)
		else $error("generators not reseeded");
	a_mid_twos: assert property (eff_mode == MODE_MID && !len10 && twos |-> gen_word == ZEROS)
		else $error("midscale not converted");
	a_posfs_twos: assert property (eff_mode == MODE_POS_FS && !len10 && twos
	                               |-> gen_word == (ONES12 ^ MID12))
		else $error("full scale not converted");
	a_checker_alt: assert property (push && eff_mode == MODE_CHECKER && !mode_change
	                                && prev_push_mode_r == MODE_CHECKER && !len10
	                                |-> gen_word == ~prev_word_r)
		else $error("checkerboard did not alternate");
	a_toggle_alt: assert property (push && eff_mode == MODE_WORD_TGL && !mode_change
	                               && prev_push_mode_r == MODE_WORD_TGL && !len10
	                               |-> gen_word == ~prev_word_r)
		else $error("word toggle did not alternate");
	a_user_first: assert property (mode_change && eff_mode == MODE_USER
	                               |=> alt_r == 1'b0)
		else $error("user pattern not starting at word 1");
	a_sync_word: assert property (eff_mode == MODE_SYNC && len10 |-> gen_word == SYNC10)
		else $error("sync word wrong");
	a_pn_nonzero: assert property (pn9_r != '0 && pn23_r != '0)
		else $error("generator locked at zero");
	a_strap_word: assert property (strap_mode_r && push |-> gen_word == MID12)
		else $error("strap pattern wrong");
	a_serial_gated: assert property (port_off |=> !spi_sclk_o && !spi_sdio_o)
		else $error("serial pins not ignored");
	a_drop_flag: assert property (sample_stb && !fifo_ready |=> overflow_o)
		else $error("drop not flagged");
	c_pn_short: cover property (push && eff_mode == MODE_PN_SHORT ##[1:40] push);
	c_checker: cover property (push && eff_mode == MODE_CHECKER ##[1:40] push);
	c_strap: cover property (strap_mode_r && push);
	c_fifo_full: cover property (!fifo_ready);
endmodule

// File: test/rx_model.sv
// Receiver model that pops pattern words from the generator
`timescale 1ns/1ps

// ****************************************
// Word sink
// ****************************************
module rx_model (
	input  wire logic        clk_i,   // Core clock
	input  wire logic        valid_i, // Word available
	input  wire logic [11:0] data_i,  // Head word
	input  wire logic        stall_i, // Hold off pops
	input  wire logic        slow_i,  // Pop every other cycle
	output logic             ready_o  // Pop request
);
	logic [11:0] got [$];
	initial ready_o = 1'b0;
	// Ready changes just after the edge that sampled it
	always @(posedge clk_i) begin
		if (valid_i && ready_o)
			got.push_back(data_i);
		ready_o <= #1 !stall_i && !(slow_i && ready_o);
	end
endmodule

// File: test/test_test_pattern_gen.sv
// Self-checking bench of the output test pattern generator
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module test_test_pattern_gen;
	localparam logic [3:0] FIX [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
	localparam logic [3:0] PAIR [3] = '{4'h4, 4'h7, 4'h8};
	logic        clk, rst_b, sclk, l10, tc, psn, fstrap, tstrap, si_clk, si_dat, stall, slow;
	logic        sclk_o, sdio_o, frame_clock_out, bco, strap, ovf, vld, rdy, ovf_seen;
	logic [11:0] adc, dout;
	logic [5:0]  ctrl;
	logic [15:0] u1, u2;
	int          fails, checks, cyc, fco_n, bco_n;

	test_pattern_gen #(.DEPTH(16)) dut (
		.core_clk_i(clk), .rst_b_i(rst_b), .sample_clk_i(sclk), .adc_sample_i(adc),
		.test_ctrl_i(ctrl), .word_len10_i(l10), .twos_comp_i(tc),
		.user_word1_i(u1), .user_word2_i(u2), .port_select_n_i(psn),
		.format_select_strap_i(fstrap), .test_pattern_strap_i(tstrap),
		.spi_sclk_i(si_clk), .spi_sdio_i(si_dat), .spi_sclk_o(sclk_o), .spi_sdio_o(sdio_o),
		.frame_clock_out_o(frame_clock_out), .bit_clock_out_o(bco), .strap_mode_o(strap),
		.overflow_o(ovf), .out_valid_o(vld), .out_ready_i(rdy), .out_data_o(dout)
	);
	rx_model rx (.clk_i(clk), .valid_i(vld), .data_i(dout), .stall_i(stall),
		.slow_i(slow), .ready_o(rdy));

	// ****************************************
	// Clock, monitors and timeout
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(frame_clock_out) fco_n++;
	always @(bco) bco_n++;
	always @(negedge clk) if (ovf === 1'b1) ovf_seen = 1'b1;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	task print_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task pulses(input int n);
		repeat (n) begin
			sclk = 1'b1;
			tick(4);
			sclk = 1'b0;
			tick(4);
		end
	endtask
	task do_reset(input logic ps, input logic ts);
		rst_b = 1'b0;
		psn = ps;
		tstrap = ts;
		tick(3);
		`CHK(vld, 1'b0)
		tick(17);
		rst_b = 1'b1;
		tick(10);
	endtask
	// Passing through code 0 restarts alternation at word 1
	task set_mode(input logic [5:0] c);
		ctrl = 6'h00;
		tick(2);
		ctrl = c;
		tick(2);
		rx.got.delete();
	endtask
	function automatic logic [11:0] fixed_w(input logic [3:0] m, input logic lw,
		input logic t, input int k);
		logic [11:0] w;
		logic        cv;
		cv = 1'b0;
		case (m)
			4'h1: begin w = lw ? 12'h200 : 12'h800; cv = 1'b1; end
			4'h2: begin w = lw ? 12'h3ff : 12'hfff; cv = 1'b1; end
			4'h3: begin w = 12'h000; cv = 1'b1; end
			4'h4: w = k % 2 ? (lw ? 12'h155 : 12'h555) : (lw ? 12'h2aa : 12'haaa);
			4'h7: w = k % 2 ? 12'h000 : (lw ? 12'h3ff : 12'hfff);
			4'h8: w = (k % 2 ? u2[11:0] : u1[11:0]) & (lw ? 12'h3ff : 12'hfff);
			4'h9: w = lw ? 12'h2aa : 12'haaa;
			4'ha: w = lw ? 12'h01f : 12'h03f;
			4'hb: w = lw ? 12'h200 : 12'h800;
			4'hc: w = lw ? 12'h263 : 12'ha33;
			default: w = t ? adc ^ 12'h800 : adc;
		endcase
		if (cv && t && lw)
			w[9] = ~w[9];
		else if (cv && t)
			w[11] = ~w[11];
		return w;
	endfunction
	function automatic logic [11:0] pn_w(input logic lng, input logic t, input int k);
		logic [22:0] s;
		logic [11:0] w;
		int          b;
		s = 23'h7fffff;
		w = 12'h000;
		for (b = 0; b < 12 * (k + 1); b++) begin
			if (lng) begin
				w = {w[10:0], ~s[22]};
				s = {s[21:0], s[22] ^ s[17]};
			end else begin
				w = {w[10:0], s[8]};
				s = {s[21:0], s[8] ^ s[4]};
			end
		end
		if (t)
			w[11] = ~w[11];
		return w;
	endfunction
	task run(input logic [3:0] m, input logic lw, input logic t, input int n);
		int k;
		l10 = lw;
		tc = t;
		set_mode({2'b00, m});
		pulses(n);
		tick(12);
		`CHK(rx.got.size(), n)
		for (k = 0; k < n; k++)
			`CHK(rx.got[k], fixed_w(m, lw, t, k))
	endtask
	task pn_case(input logic lng, input logic t, input logic [5:0] c);
		int k;
		tc = t;
		set_mode({2'b00, c[3:0]});
		pulses(3);
		tick(12);
		for (k = 0; k < 3; k++)
			`CHK(rx.got[k], pn_w(lng, t, k))
		ctrl = c;
		tick(2);
		ctrl = {2'b00, c[3:0]};
		tick(2);
		rx.got.delete();
		pulses(2);
		tick(12);
		for (k = 0; k < 2; k++)
			`CHK(rx.got[k], pn_w(lng, t, k))
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_fixed;
		for (int i = 0; i < 9; i++)
			for (int j = 0; j < 4; j++)
				run(FIX[i], j[1], j[0], 2);
	endtask
	task t_pairs;
		slow = 1'b1;
		for (int i = 0; i < 3; i++)
			for (int j = 0; j < 4; j++)
				run(PAIR[i], j[1], j[0], 3);
		slow = 1'b0;
	endtask
	task t_pn;
		l10 = 1'b1;
		pn_case(1'b0, 1'b0, 6'h26);
		pn_case(1'b1, 1'b1, 6'h15);
		l10 = 1'b0;
	endtask
	task t_overflow;
		stall = 1'b1;
		tc = 1'b0;
		ovf_seen = 1'b0;
		set_mode(6'h0a);
		pulses(17);
		tick(6);
		`CHK(ovf_seen, 1'b1)
		`CHK(vld, 1'b1)
		stall = 1'b0;
		tick(40);
		`CHK(rx.got.size(), 16)
		`CHK(rx.got[15], 12'h03f)
	endtask
	task t_strap;
		do_reset(1'b1, 1'b1);
		`CHK(strap, 1'b1)
		si_clk = 1'b1;
		si_dat = 1'b1;
		tick(4);
		`CHK(sclk_o, 1'b0)
		`CHK(sdio_o, 1'b0)
		rx.got.delete();
		fco_n = 0;
		bco_n = 0;
		pulses(2);
		tick(12);
		`CHK(rx.got.size(), 2)
		`CHK(rx.got[0], 12'h800)
		`CHK(rx.got[1], 12'h800)
		`CHK(fco_n, 4)
		`CHK(bco_n > 20, 1'b1)
		do_reset(1'b0, 1'b1);
		`CHK(strap, 1'b0)
		`CHK(sclk_o, 1'b1)
		// Port off, format strap high: normal data in twos complement
		fstrap = 1'b1;
		do_reset(1'b1, 1'b0);
		`CHK(strap, 1'b0)
		rx.got.delete();
		pulses(1);
		tick(12);
		`CHK(rx.got.size(), 1)
		`CHK(rx.got[0], 12'hdc3)
	endtask

	initial begin
		{sclk, l10, tc, psn, fstrap, tstrap, si_clk, si_dat, stall, slow} = '0;
		rst_b = 1'b0;
		adc = 12'h5c3;
		ctrl = 6'h00;
		u1 = 16'hf5a3;
		u2 = 16'h0c3c;
		{fails, checks, cyc, fco_n, bco_n} = '0;
		ovf_seen = 1'b0;
		#1;
		do_reset(1'b0, 1'b0);
		t_fixed();
		t_pairs();
		t_pn();
		t_overflow();
		t_strap();
		print_verdict();
	end
endmodule
